/* File: hw/sas_pkg.sv */
package sas_pkg;
  localparam int RES_BITS = 8;
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  // Least settling before the top-bit decision, in ns
  localparam int MSB_SETTLE_NS = 550;
  localparam int MSB_SETTLE_CYC = (MSB_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Longest conversion, in ns
  localparam int CONV_MAX_NS = 9000;
  localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
  // Least start pulse width the host must give, in ns
  localparam int START_MIN_NS = 200;
  localparam int START_MIN_CYC = (START_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SAR_RESET = 8'h00;
  localparam logic [7:0] SAR_START = 8'h80;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  typedef enum logic [3:0] {
    SAS_IDLE = 4'b0001,
    SAS_HOLD = 4'b0010,
    SAS_WAIT = 4'b0100,
    SAS_CONV = 4'b1000
  } sas_state_t;
endpackage

/* File: hw/sas_sequencer.sv */
`timescale 1ns/100ps
// Functional notes
// - Start low: busy low, load top bit only.
// - Clear trial bit when DAC exceeds input.
// - Same edge sets next lower trial bit.
// - Eight decisions, then busy returns high.
// - Read low drives result; else outputs off.
// - Valid data 7.5 to 8.5 clocks later; this code takes eleven clock edges after start release.
// - Start held low: hold reset, no decisions.
// - After start release, wait rise then fall.
// - New start pulse restarts any conversion.
// - Enabled outputs show result as busy rises.
// - Free-run: one conversion per eight clocks; with the test glue this code takes fourteen.
// - Eight-bit successive-approximation result and code.
// - Conversion completes within 9 us.
module sas_sequencer #(
  parameter int WIDTH = sas_pkg::RES_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_n,
  input wire logic dac_above,
  input wire logic read_n,
  output logic busy_n,
  output logic [WIDTH-1:0] dac_code,
  output logic [WIDTH-1:0] data_out,
  output logic [WIDTH-1:0] data_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // One trial bit per edge; below two bits there is nothing to search
  if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
    $error("WIDTH must lie between 2 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start input crossing
  // The host pulse has no timing relation to clk, so it passes two flops;
  // the price is two edges of latency before a restart takes hold.

  logic start_sync_n;

  sas_sync #(
    .RESET_VAL(1'b1)
  ) u_start_sync (
    .clk(clk),
    .rst(rst),
    .d(start_n),
    .q(start_sync_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared decodes
  // The fabric has one clock edge, so a documented falling edge is a
  // rising edge here; the hold state supplies the extra edge of settling.

  sas_pkg::sas_state_t state_r;
  sas_pkg::sas_state_t state_nxt;
  logic [WIDTH-1:0] trial_r;
  logic [WIDTH-1:0] trial_nxt;
  logic [WIDTH-1:0] trial_dn;
  logic busy_n_r;
  logic busy_n_nxt;
  logic [WIDTH-1:0] sar_r;
  logic [WIDTH-1:0] sar_nxt;
  logic [WIDTH-1:0] data_r;
  logic [WIDTH-1:0] data_nxt;
  logic restart;
  logic decide;
  logic last_bit;

  // Restart wins over everything, whatever the state
  assign restart = ~start_sync_n;
  // The hold-to-wait edge makes no decision; wait and convert edges do
  assign decide = ~restart &
    ((state_r == sas_pkg::SAS_WAIT) | (state_r == sas_pkg::SAS_CONV));
  assign last_bit = trial_r[0];
  assign trial_dn = trial_r >> 1;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  always_comb begin
    state_nxt = state_r;
    if (restart) begin
      state_nxt = sas_pkg::SAS_HOLD;
    end else begin
      case (state_r)
        sas_pkg::SAS_IDLE: begin
          state_nxt = sas_pkg::SAS_IDLE;
        end
        sas_pkg::SAS_HOLD: begin
          // Release seen: spend one edge letting the top bit settle
          state_nxt = sas_pkg::SAS_WAIT;
        end
        sas_pkg::SAS_WAIT: begin
          state_nxt = sas_pkg::SAS_CONV;
        end
        sas_pkg::SAS_CONV: begin
          if (last_bit) begin
            state_nxt = sas_pkg::SAS_IDLE;
          end
        end
        default: begin
          state_nxt = sas_pkg::SAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= sas_pkg::SAS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trial marker: one-hot pointer to the bit under decision

  always_comb begin
    trial_nxt = trial_r;
    if (restart) begin
      trial_nxt = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (decide) begin
      trial_nxt = trial_dn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trial_r <= '0;
    end else begin
      trial_r <= trial_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy flag
  // In free-running use the glue sees busy high for a few edges only, so
  // it must latch the result while busy stands high.

  always_comb begin
    busy_n_nxt = busy_n_r;
    if (restart) begin
      busy_n_nxt = 1'b0;
    end else if (decide && last_bit) begin
      busy_n_nxt = 1'b1;
    end else if (state_r == sas_pkg::SAS_IDLE) begin
      busy_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_n_r <= 1'b1;
    end else begin
      busy_n_r <= busy_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Approximation register, one slice per bit

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic bit_nxt;

    always_comb begin
      bit_nxt = sar_r[i];
      if (restart) begin
        // Top bit set, all others cleared: the DAC starts at half scale
        bit_nxt = (i == WIDTH - 1);
      end else if (decide) begin
        if (trial_r[i] && dac_above) begin
          bit_nxt = 1'b0;
        end
        if (trial_dn[i]) begin
          bit_nxt = 1'b1;
        end
      end
    end

    assign sar_nxt[i] = bit_nxt;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sar_r <= WIDTH'(sas_pkg::SAR_RESET);
    end else begin
      sar_r <= sar_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result latch
  // Follows the register live so enabled pins already hold the final
  // code on the edge where busy returns high.

  always_comb begin
    data_nxt = sar_nxt;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_r <= WIDTH'(sas_pkg::SAR_RESET);
    end else begin
      data_r <= data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Reading only enables drivers; the stored result is never touched.

  assign busy_n = busy_n_r;
  assign dac_code = sar_r;
  assign data_out = data_r;
  assign data_oe = {WIDTH{~read_n}};
endmodule

/* File: hw/sas_sync.sv */
`timescale 1ns/100ps
module sas_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      q_r <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

/* File: testbench/sas_cmp_model.sv */
`timescale 1ns/100ps
module sas_cmp_model (
  input wire logic [7:0] code,
  input wire logic [7:0] vin,
  output logic above
);
  // Ideal comparator, so the result must equal vin exactly
  assign above = code > vin;
endmodule

/* File: testbench/sas_sequencer_properties.sv */
`timescale 1ns/100ps
module sas_sequencer_properties #(parameter int WIDTH = 8) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_n,
  input wire logic dac_above,
  input wire logic read_n,
  input wire logic busy_n,
  input wire logic [WIDTH-1:0] dac_code,
  input wire logic [WIDTH-1:0] data_out,
  input wire logic [WIDTH-1:0] data_oe
);
  localparam logic [WIDTH-1:0] TOP = {1'b1, {(WIDTH-1){1'b0}}};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe; data_oe == {WIDTH{!read_n}}; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_out; data_out == dac_code; endproperty
  a_out: assert property (p_out) else $error("out");
  property p_hold; !start_n [*3] |=> dac_code == TOP && !busy_n; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_msb; $fell(busy_n) |-> dac_code == TOP; endproperty
  a_msb: assert property (p_msb) else $error("msb");
  property p_sync; $fell(busy_n) |-> !$past(start_n, 3); endproperty
  a_sync: assert property (p_sync) else $error("sync");
  property p_long; $rose(busy_n) |-> !$past(busy_n, 9); endproperty
  a_long: assert property (p_long) else $error("long");
  property p_done;
    $rose(start_n) ##1 start_n [*8] ##1 start_n |-> ##2 busy_n && !$past(busy_n);
  endproperty
  a_done: assert property (p_done) else $error("done");
  property p_keep; busy_n && $past(busy_n) |-> $stable(dac_code); endproperty
  a_keep: assert property (p_keep) else $error("keep");
endmodule

/* File: testbench/sas_sequencer_test.sv */
`timescale 1ns/100ps
module sas_sequencer_test;
  logic clk = 0, rst = 1, start_n = 1, read_n = 1, dac_above, busy_n;
  logic [7:0] vin = 8'h00, dac_code, data_out, data_oe;
  logic [7:0] vals [6] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'ha5};
  int n_mismatch = 0, samples_checked = 0;
  initial forever #4 clk = ~clk;
  sas_cmp_model u_sas_cmp_model (.code(dac_code), .vin(vin), .above(dac_above));
  sas_sequencer u_sas_sequencer (.clk(clk), .rst(rst), .start_n(start_n),
    .dac_above(dac_above), .read_n(read_n), .busy_n(busy_n), .dac_code(dac_code),
    .data_out(data_out), .data_oe(data_oe));
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic conv(input logic [7:0] v);
    int k;
    vin = v;
    start_n = 0;
    tick(sas_pkg::START_MIN_CYC);
    cmp(dac_code, 8'h80);
    cmp({7'h00, busy_n}, 8'h00);
    start_n = 1;
    k = 0;
    while (busy_n !== 1'b1 && k < 40) begin
      cmp(data_oe, 8'h00);
      tick(1);
      k++;
    end
    // Two synchroniser edges, one settling edge, then one edge per bit
    cmp(8'(k), 8'(sas_pkg::RES_BITS + 3));
    if (k == 40) results();
    read_n = 0;
    tick(1);
    cmp(data_oe, 8'hff);
    cmp(data_out, v);
    read_n = 1;
    // Comparator flips after the end; a live register would follow it
    vin = ~v;
    tick(3);
    cmp(data_out, v);
    cmp(data_oe, 8'h00);
  endtask
  task automatic free_run(input logic [7:0] v);
    int k;
    int n;
    logic prev;
    vin = v;
    read_n = 0;
    n = 0;
    k = 0;
    prev = busy_n;
    while (n < 3 && k < 100) begin
      // Glue inverts busy into the start input within the same clock
      start_n = ~busy_n;
      tick(1);
      k++;
      if (prev === 1'b0 && busy_n === 1'b1) begin
        cmp(data_oe, 8'hff);
        cmp(data_out, v);
        n++;
      end
      prev = busy_n;
    end
    cmp(8'(n), 8'h03);
    read_n = 1;
    start_n = 1;
    tick(1);
  endtask
  task automatic restart;
    vin = 8'h33;
    start_n = 0;
    tick(sas_pkg::START_MIN_CYC);
    start_n = 1;
    tick(6);
    conv(8'hc5);
  endtask
  initial begin
    tick(2);
    rst = 0;
    foreach (vals[i]) conv(vals[i]);
    free_run(8'h5a);
    restart();
    results();
  end
endmodule
bind sas_sequencer sas_sequencer_properties #(.WIDTH(WIDTH)) u_sas_sequencer_properties (
  .clk(clk), .rst(rst), .start_n(start_n), .dac_above(dac_above), .read_n(read_n),
  .busy_n(busy_n), .dac_code(dac_code), .data_out(data_out), .data_oe(data_oe));
